// File: core/cfr_card_cmd.sv
// Purpose: card file read / file-memory compare command interpreter
// Assumes: one card access port and one byte stream, both synchronous
// Notes:   response words fill in during the final copy while busy; status code and done appear only when the command completes
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - A process number of 2 in the control word's low byte copies a card file into memory.
// - The level bit picks unit level 0 or 1, and only the matching unit runs the command.
// - Bit 8 clear returns file contents, set returns only the file's element count.
// - Bit 9 clear treats the file as comma text, set treats it as binary words.
// - For comma text bit 10 picks one-word elements when clear and double words when set.
// - Drive letter G resolves to card slot 1 and drive letter H to card slot 2.
// - The start offset counts words for binary and word text, elements for double-word text.
// - The read amount is 1 to 3E7 words, or 1 to 1F3 elements for double-word text.
// - Comma text uses one-byte separators after 4 or 8 digits; CR or LF gives code 2.
// - A content read stores the words read; a count read stores the count as two words.
// - Codes are 00 success, 01 bad offset or amount, 02 file or type error, 03 no file.
// - Process number 3 compares a file with memory and answers only with a code.
// - Compare gives code 04 when any word differs or the file is shorter than asked.
module cfr_card_cmd
  import cfr_pkg::*;
(
  // clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_rst_b,
  // register port
  input  wire logic [10:0]   i_addr,
  input  wire logic [15:0]   i_wr_data,
  input  wire logic          i_wr,
  input  wire logic          i_rd,
  output logic      [15:0]   o_rd_data,
  // card file access
  output logic               o_card_req,
  output logic      [1:0]    o_card_slot,
  output logic      [111:0]  o_card_name,
  input  wire logic          i_card_ack,
  input  wire logic          i_card_found,
  input  wire logic          i_card_ioerr,
  // file byte stream
  input  wire logic          i_byte_valid,
  input  wire logic [7:0]    i_byte,
  input  wire logic          i_byte_last,
  output logic               o_byte_ready,
  // status
  output logic               o_busy
);
  function automatic logic in_resp(input logic [10:0] a);
    return a >= RESP_BASE;
  endfunction
  function automatic logic [1:0] drive_slot(input logic [7:0] d);
    if (d == DRIVE_G) return SLOT_1;
    if (d == DRIVE_H) return SLOT_2;
    return SLOT_NONE;
  endfunction

  cfr_strm_if #(.W(BYTE_W)) byte_if ();
  cfr_strm_if #(.W(ELEM_W)) elem_if ();

  // software registers
  logic [15:0] ctrl, next_ctrl, len, next_len, offs, next_offs, amt, next_amt;
  logic [15:0] name [NAME_N], next_name [NAME_N];
  logic        level, next_level;
  logic [15:0] next_rd_data;
  // engine state
  cfr_state_t  state, next_state;
  logic        m_cmp, next_m_cmp, m_cnt, next_m_cnt, m_bin, next_m_bin;
  logic        m_dbl, next_m_dbl, done, next_done;
  logic [1:0]  slot, next_slot;
  logic [31:0] idx, next_idx, win_end;
  logic [10:0] got, next_got, copy_i, next_copy_i, copy_n, next_copy_n, mis_cyc, next_mis_cyc;
  localparam logic [10:0] MIS_LIMIT = 11'h44C;
  logic [7:0]  fail, next_fail, code, next_code;
  // memories
  logic [15:0] resp_mem  [RESP_DEPTH];
  logic [15:0] stage_mem [RESP_DEPTH];
  logic        go, start_ok, sw_resp_wr, win, e_ok, st_we;
  logic [9:0]  st_a0, st_a1;
  logic [15:0] copy_word, amt_max;
  logic [31:0] mem_pair;
  logic [ELEM_W-1:0] e;

  cfr_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_valid (i_byte_valid),
    .i_data  ({i_byte_last, i_byte}),
    .o_ready (o_byte_ready),
    .out     (byte_if.src)
  );
  cfr_parse u_parse (
    .i_clk    (i_clk),
    .i_rst_b  (i_rst_b),
    .i_clear  (state == S_IDLE),
    .i_bin    (m_bin),
    .i_dbl    (m_dbl),
    .byte_in  (byte_if.snk),
    .elem_out (elem_if.src)
  );
  genvar gi;
  generate
    for (gi = 0; gi < NAME_N; gi++) begin : g_name
      assign o_card_name[111-16*gi -: 16] = name[gi];
    end
  endgenerate

  assign o_busy       = (state != S_IDLE);
  assign o_card_req   = (state == S_OPEN);
  assign o_card_slot  = slot;
  assign elem_if.ready = (state == S_RUN);
  assign e            = elem_if.data;
  assign go           = i_wr && (i_addr == REG_GO) && i_wr_data[B_GO] && (state == S_IDLE);
  assign start_ok     = (ctrl[7:0] == PROC_READ || ctrl[7:0] == PROC_CMP)
                        && (ctrl[B_LEVEL] == level)
                        && ctrl[B_CCE];
  assign sw_resp_wr   = i_wr && in_resp(i_addr) && (state == S_IDLE);
  assign amt_max      = (ctrl[B_DBL] && !ctrl[B_BIN]) ? AMT_MAX_DBL : AMT_MAX_WORD;
  assign win_end      = {16'h0000, offs} + {16'h0000, amt};
  // offset and amount count elements, which are words except in double mode
  assign win          = elem_if.valid && !e[E_EMPTY] && !e[E_ERR]
                        && (idx >= {16'h0000, offs}) && (idx < win_end);
  assign e_ok         = win && (fail == RC_OK) && !m_cnt && (state == S_RUN);
  assign st_we        = e_ok && !m_cmp;
  assign st_a0        = m_dbl ? {got[8:0], 1'b0} : got[9:0];
  assign st_a1        = {got[8:0], 1'b1};
  assign mem_pair     = m_dbl ? {resp_mem[st_a0], resp_mem[st_a1]}
                              : {16'h0000, resp_mem[st_a0]};
  assign copy_word    = m_cnt ? ((copy_i == 11'h000) ? idx[31:16] : idx[15:0])
                              : stage_mem[copy_i[9:0]];

  // register file
  always_comb begin
    next_ctrl    = ctrl;
    next_len     = len;
    next_offs    = offs;
    next_amt     = amt;
    next_level   = level;
    next_name    = name;
    next_rd_data = 16'h0000;
    // command words are frozen while a command runs
    if (i_wr && state == S_IDLE) begin
      if (i_addr == REG_CTRL) next_ctrl = i_wr_data;
      if (i_addr == REG_LEN) next_len = i_wr_data;
      if (i_addr == REG_OFFS) next_offs = i_wr_data;
      if (i_addr == REG_AMT) next_amt = i_wr_data;
      if (i_addr == REG_LEVEL) next_level = i_wr_data[0];
      for (int k = 0; k < NAME_N; k++) begin
        if (i_addr == REG_NAME0 + 11'(k)) next_name[k] = i_wr_data;
      end
    end
    if (i_rd) begin
      if (in_resp(i_addr)) next_rd_data = resp_mem[10'(i_addr - RESP_BASE)];
      else if (i_addr == REG_CTRL) next_rd_data = ctrl;
      else if (i_addr == REG_LEN) next_rd_data = len;
      else if (i_addr == REG_OFFS) next_rd_data = offs;
      else if (i_addr == REG_AMT) next_rd_data = amt;
      else if (i_addr == REG_LEVEL) next_rd_data = {15'h0000, level};
      else if (i_addr == REG_STAT) next_rd_data = {6'h00, o_busy, done, code};
      else if (i_addr >= REG_NAME0 && i_addr < REG_LEN) begin
        next_rd_data = name[3'(i_addr - REG_NAME0)];
      end
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl      <= 16'h0000;
      len       <= 16'h0000;
      offs      <= 16'h0000;
      amt       <= 16'h0000;
      level     <= 1'b0;
      name      <= '{default: 16'h0000};
      o_rd_data <= 16'h0000;
    end else begin
      ctrl      <= next_ctrl;
      len       <= next_len;
      offs      <= next_offs;
      amt       <= next_amt;
      level     <= next_level;
      name      <= next_name;
      o_rd_data <= next_rd_data;
    end
  end

  // command engine
  always_comb begin
    next_state  = state;
    next_m_cmp  = m_cmp;
    next_m_cnt  = m_cnt;
    next_m_bin  = m_bin;
    next_m_dbl  = m_dbl;
    next_done   = done;
    next_slot   = slot;
    next_idx    = idx;
    next_got    = got;
    next_copy_i = copy_i;
    next_copy_n = copy_n;
    next_fail   = fail;
    next_code   = code;
    next_mis_cyc = (o_busy && fail == RC_NOMATCH) ? mis_cyc + 11'h001 : 11'h000;
    case (state)
      S_IDLE: begin
        if (go && start_ok) begin
          next_m_cmp  = (ctrl[7:0] == PROC_CMP);
          next_m_cnt  = (ctrl[7:0] == PROC_READ) && ctrl[B_COUNT];
          next_m_bin  = ctrl[B_BIN];
          next_m_dbl  = ctrl[B_DBL] && !ctrl[B_BIN];
          next_done   = 1'b0;
          next_idx    = '0;
          next_got    = '0;
          next_copy_i = '0;
          next_copy_n = '0;
          next_fail   = RC_OK;
          next_slot   = drive_slot(name[0][15:8]);
          next_state  = S_OPEN;
          if (next_slot == SLOT_NONE) begin
            next_fail  = RC_NOFILE;
            next_state = S_FIN;
          end else if (!next_m_cnt && (amt < AMT_MIN || amt > amt_max)) begin
            next_fail  = RC_RANGE;
            next_state = S_FIN;
          end
        end
      end
      S_OPEN: begin
        if (i_card_ack) begin
          next_state = S_RUN;
          if (!i_card_found) begin
            next_fail  = RC_NOFILE;
            next_state = S_FIN;
          end else if (i_card_ioerr) begin
            next_fail  = RC_IO;
            next_state = S_FIN;
          end
        end
      end
      S_RUN: begin
        if (elem_if.valid) begin
          if (!e[E_EMPTY] && !e[E_ERR]) next_idx = idx + 32'h1;
          if (e[E_ERR] && fail == RC_OK) next_fail = RC_IO;
          if (e_ok) begin
            next_got = got + 11'h001;
            if (m_cmp && (m_dbl ? e[31:0] : {16'h0000, e[15:0]}) != mem_pair) begin
              next_fail = RC_NOMATCH;
            end
          end
          // the stream is always drained to its end so the buffer starts clean
          if (e[E_LAST]) begin
            next_state = S_COPY;
            if (next_fail == RC_OK) begin
              if (m_cnt) next_copy_n = 11'h002;
              else if ({5'h00, next_got} < amt) begin
                next_fail = m_cmp ? RC_NOMATCH : RC_RANGE;
              end else if (!m_cmp) begin
                next_copy_n = m_dbl ? {amt[9:0], 1'b0} : amt[10:0];
              end
            end
          end
        end
      end
      S_COPY: begin
        if (copy_i == copy_n) next_state = S_FIN;
        else next_copy_i = copy_i + 11'h001;
      end
      S_FIN: begin
        next_code  = fail;
        next_done  = 1'b1;
        next_state = S_IDLE;
      end
      default: next_state = S_IDLE;
    endcase
  end
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state  <= S_IDLE;
      m_cmp  <= 1'b0;
      m_cnt  <= 1'b0;
      m_bin  <= 1'b0;
      m_dbl  <= 1'b0;
      done   <= 1'b0;
      slot   <= SLOT_NONE;
      idx    <= '0;
      got    <= '0;
      copy_i <= '0;
      copy_n <= '0;
      fail   <= RC_OK;
      code   <= RC_OK;
      mis_cyc <= '0;
    end else begin
      state  <= next_state;
      m_cmp  <= next_m_cmp;
      m_cnt  <= next_m_cnt;
      m_bin  <= next_m_bin;
      m_dbl  <= next_m_dbl;
      done   <= next_done;
      slot   <= next_slot;
      idx    <= next_idx;
      got    <= next_got;
      copy_i <= next_copy_i;
      copy_n <= next_copy_n;
      fail   <= next_fail;
      code   <= next_code;
      mis_cyc <= next_mis_cyc;
    end
  end

  // staging keeps the visible response area untouched until the copy
  always_ff @(posedge i_clk) begin
    if (st_we) begin
      stage_mem[st_a0] <= m_dbl ? e[31:16] : e[15:0];
      if (m_dbl) stage_mem[st_a1] <= e[15:0];
    end
  end
  always_ff @(posedge i_clk) begin
    if (state == S_COPY && copy_i != copy_n) begin
      resp_mem[copy_i[9:0]] <= copy_word;
    end else if (sw_resp_wr) begin
      resp_mem[10'(i_addr - RESP_BASE)] <= i_wr_data;
    end
  end
  property p_proc_ok;
    @(posedge i_clk) disable iff (!i_rst_b)
    $rose(o_busy) |-> ($past(ctrl[7:0]) == PROC_READ || $past(ctrl[7:0]) == PROC_CMP);
  endproperty
  a_proc_ok: assert property (p_proc_ok) else $error("bad process started");
  property p_level;
    @(posedge i_clk) disable iff (!i_rst_b)
    $rose(o_busy) |-> ($past(ctrl[B_LEVEL]) == $past(level));
  endproperty
  a_level: assert property (p_level) else $error("wrong level started");
  property p_cce;
    @(posedge i_clk) disable iff (!i_rst_b)
    (go && !ctrl[B_CCE]) |=> !o_busy;
  endproperty
  a_cce: assert property (p_cce) else $error("started without cce");
  property p_slot;
    @(posedge i_clk) disable iff (!i_rst_b)
    o_card_req |-> (o_card_slot == SLOT_1 || o_card_slot == SLOT_2);
  endproperty
  a_slot: assert property (p_slot) else $error("no slot on request");
  property p_amt;
    @(posedge i_clk) disable iff (!i_rst_b)
    (state == S_RUN && !m_cnt) |-> (amt >= AMT_MIN && amt <= (m_dbl ? AMT_MAX_DBL : AMT_MAX_WORD));
  endproperty
  a_amt: assert property (p_amt) else $error("amount out of range");
  property p_cmp_nodata;
    @(posedge i_clk) disable iff (!i_rst_b)
    (state == S_COPY && m_cmp) |-> (copy_n == 11'h000);
  endproperty
  a_cmp_nodata: assert property (p_cmp_nodata) else $error("compare wrote data");
  property p_mismatch;
    @(posedge i_clk) disable iff (!i_rst_b)
    (o_busy && fail == RC_NOMATCH)
      |-> ((mis_cyc < MIS_LIMIT) and (state == S_FIN |=> (done && code == RC_NOMATCH)));
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("mismatch not reported");
  property p_code_range;
    @(posedge i_clk) disable iff (!i_rst_b)
    $rose(done) |-> (code <= RC_NOMATCH && $past(state) == S_FIN);
  endproperty
  a_code_range: assert property (p_code_range) else $error("bad completion");
  property p_late_result;
    @(posedge i_clk) disable iff (!i_rst_b)
    o_busy |-> (!done && $stable(code));
  endproperty
  a_late_result: assert property (p_late_result) else $error("result seen early");
endmodule
`default_nettype wire

// File: core/cfr_fifo.sv
// Purpose: byte buffer between the card stream and the parser
// Assumes: DEPTH is a power of two
// Notes:   ready drops when full, so the card source stalls
`timescale 1ns/1ps
`default_nettype none
module cfr_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_b,
  // fill side
  input  wire logic             i_valid,
  input  wire logic [WIDTH-1:0] i_data,
  output logic                  o_ready,
  // drain side
  cfr_strm_if.src               out
);
  localparam int unsigned AW = $clog2(DEPTH);
  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("fifo depth must be a power of two");
    end
  endgenerate
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr, rd, next_wr, next_rd;
  logic             full, empty, push, pop;
  assign full      = (wr[AW] != rd[AW]) && (wr[AW-1:0] == rd[AW-1:0]);
  assign empty     = (wr == rd);
  assign o_ready   = !full;
  assign out.valid = !empty;
  assign out.data  = mem[rd[AW-1:0]];
  assign push      = i_valid && !full;
  assign pop       = out.ready && !empty;
  always_comb begin
    next_wr = wr + (AW+1)'(push);
    next_rd = rd + (AW+1)'(pop);
  end
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr <= '0;
      rd <= '0;
    end else begin
      wr <= next_wr;
      rd <= next_rd;
    end
  end
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr[AW-1:0]] <= i_data;
    end
  end
endmodule
`default_nettype wire

// File: core/cfr_parse.sv
// Purpose: turns file bytes into elements (binary words or comma text)
// Assumes: i_clear high while no command runs
// Notes:   one element in flight; bytes stall while it waits
`timescale 1ns/1ps
`default_nettype none
module cfr_parse
  import cfr_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  // mode
  input  wire logic i_clear,
  input  wire logic i_bin,
  input  wire logic i_dbl,
  // streams
  cfr_strm_if.snk   byte_in,
  cfr_strm_if.src   elem_out
);
  function automatic logic [4:0] hex_val(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) return {1'b1, c[3:0]};
    if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66)) begin
      return {1'b1, 4'(c[3:0] + 4'h9)};
    end
    return 5'h00;
  endfunction
  logic [31:0]       acc, next_acc;
  logic [3:0]        dig, next_dig, exp_dig;
  logic              half, next_half, ov, next_ov, take, lst;
  logic [7:0]        hi, next_hi, b;
  logic [ELEM_W-1:0] od, next_od;
  logic [4:0]        hv;
  assign byte_in.ready = !ov || elem_out.ready;
  assign elem_out.valid = ov;
  assign elem_out.data  = od;
  assign take    = byte_in.valid && byte_in.ready;
  assign b       = byte_in.data[7:0];
  assign lst     = byte_in.data[BYTE_LAST];
  assign hv      = hex_val(b);
  assign exp_dig = i_dbl ? DIG_DBL : DIG_WORD;
  always_comb begin
    next_acc  = acc;
    next_dig  = dig;
    next_half = half;
    next_hi   = hi;
    next_od   = od;
    next_ov   = ov && !elem_out.ready;
    if (i_clear) begin
      next_acc  = '0;
      next_dig  = '0;
      next_half = 1'b0;
      next_ov   = 1'b0;
    end else if (take) begin
      next_ov = 1'b1;
      if (i_bin) begin
        // a dangling odd byte at the end is a file type error
        next_half = !half;
        next_hi   = b;
        next_ov   = half || lst;
        next_od   = {!half, lst, 1'b0, 16'h0000, hi, b};
      end else if (hv[4]) begin
        next_acc = {acc[27:0], hv[3:0]};
        next_dig = (dig == 4'hF) ? dig : dig + 4'h1;
        next_ov  = lst;
        next_od  = {next_dig != exp_dig, lst, 1'b0, next_acc};
      end else if (b == CHR_CR || b == CHR_LF) begin
        next_od = {1'b1, lst, 1'b1, acc};
      end else begin
        // trailing separator at the end of the file closes nothing
        next_od  = {dig != exp_dig && !(lst && dig == 4'h0), lst,
                    dig == 4'h0, acc};
        next_acc = '0;
        next_dig = '0;
      end
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      acc  <= '0;
      dig  <= '0;
      half <= 1'b0;
      hi   <= '0;
      od   <= '0;
      ov   <= 1'b0;
    end else begin
      acc  <= next_acc;
      dig  <= next_dig;
      half <= next_half;
      hi   <= next_hi;
      od   <= next_od;
      ov   <= next_ov;
    end
  end
  property p_crlf_err;
    @(posedge i_clk) disable iff (!i_rst_b)
    (take && !i_clear && !i_bin && (b == CHR_CR || b == CHR_LF))
      |=> (elem_out.valid && elem_out.data[E_ERR]);
  endproperty
  a_crlf_err: assert property (p_crlf_err) else $error("crlf not flagged");
endmodule
`default_nettype wire

// File: dv/cfr_card_model.sv
// Purpose: card side model that answers the open request and streams file bytes
// Assumes: the bench loads mem and len before the commands that need new file bytes
// Notes:   idle byte lines show a pattern taken from the byte position, which holds while idle, never stale data
`timescale 1ns/1ps
`default_nettype none
module cfr_card_model (
  input  wire logic  i_clk,
  input  wire logic  i_rst_b,
  input  wire logic  i_req,
  input  wire logic  i_found,
  input  wire logic  i_ready,
  input  wire logic  i_stall,
  output logic       o_ack,
  output logic       o_valid,
  output logic [7:0] o_byte,
  output logic       o_last
);
  logic [7:0] mem [0:31];
  int         len = 1;
  int         pos;
  logic       run;
  assign o_valid = run && !i_stall;
  assign o_byte  = o_valid ? mem[pos] : 8'(pos) ^ 8'hA5;
  assign o_last  = (pos == len - 1);
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_ack <= 1'b0;
      run   <= 1'b0;
      pos   <= 0;
    end else begin
      o_ack <= i_req && !o_ack;
      if (o_ack) begin
        run <= i_found;
        pos <= 0;
      end else if (o_valid && i_ready) begin
        pos <= pos + 1;
        run <= !o_last;
      end
    end
  end
endmodule
`default_nettype wire

// File: dv/testbench.sv
// Purpose: self-checking bench for the card file command interpreter
// Assumes: unit level register resets to 0
// Notes:   file bytes are random or fixed text
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cfr_pkg::*;
  logic i_clk = 1'b0, i_rst_b = 1'b0, i_wr = 1'b0, i_rd = 1'b0, stall = 1'b0, found = 1'b1;
  logic [10:0] i_addr = '0;
  logic [15:0] i_wr_data = '0, o_rd_data, d;
  logic        req, ack, bval, blast, brdy, o_busy, ioerr = 1'b0;
  logic [111:0] cname;
  logic [1:0]  slot, slot_seen;
  logic [7:0]  bdat;
  int          failures = 0, n_checks = 0, seed = 32'h03AC, k;
  cfr_card_cmd cfr_card_cmd_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data), .o_card_req(req),
    .o_card_slot(slot), .o_card_name(cname), .i_card_ack(ack), .i_card_found(found),
    .i_card_ioerr(ioerr), .i_byte_valid(bval), .i_byte(bdat), .i_byte_last(blast),
    .o_byte_ready(brdy), .o_busy(o_busy));
  cfr_card_model cfr_card_model_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_req(req),
    .i_found(found && !ioerr), .i_ready(brdy), .i_stall(stall), .o_ack(ack), .o_valid(bval),
    .o_byte(bdat), .o_last(blast));
  initial forever #25 i_clk = ~i_clk;
  // random stalls make the byte source slow as well as prompt
  always @(posedge i_clk) stall <= ($random(seed) % 4) == 0;
  task finish_test();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [10:0] a, input logic [15:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_wr_data <= v;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task rdc(input logic [10:0] a, input logic [15:0] exp);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rd_data;
    check(d, exp);
  endtask
  task load(input string s);
    for (int i = 0; i < s.len(); i++) cfr_card_model_inst.mem[i] = s[i];
    cfr_card_model_inst.len = s.len();
  endtask
  function logic [15:0] bw(input int j);
    return {cfr_card_model_inst.mem[2*j], cfr_card_model_inst.mem[2*j+1]};
  endfunction
  // three command words always carry length 0003 from the requester
  task run(input logic [15:0] c, input logic [15:0] nm, input logic [15:0] off,
           input logic [15:0] amt, input logic [7:0] code);
    int i;
    wr(REG_CTRL, c);
    wr(REG_NAME0, nm);
    wr(REG_LEN, 16'h0003);
    wr(REG_OFFS, off);
    wr(REG_AMT, amt);
    wr(REG_GO, 16'h0001);
    #1;
    for (i = 0; i < 3000 && o_busy !== 1'b0; i++) begin
      if (req === 1'b1) slot_seen = slot;
      @(posedge i_clk);
      #1;
    end
    if (i == 3000) begin
      failures++;
      finish_test();
    end
    rdc(REG_STAT, {8'h01, code});
    check(cname[111:96], nm);
    $display("command %h done, code %h", c, code);
  endtask
  initial begin
    repeat (8) @(posedge i_clk);
    i_rst_b <= 1'b1;
    @(posedge i_clk);
    #1;
    check({o_rd_data[15:1], o_busy}, 16'h0000);
    for (k = 0; k < 8; k++) cfr_card_model_inst.mem[k] = 8'($random(seed));
    cfr_card_model_inst.len = 8;
    run(16'h0A02, 16'h473A, 16'h0001, 16'h0002, RC_OK);
    check({14'h0, slot_seen}, 16'h0001);
    rdc(RESP_BASE, bw(1));
    rdc(RESP_BASE + 11'h001, bw(2));
    load("1234,5678,9abc,def0");
    run(16'h0902, 16'h483A, 16'h0000, 16'h0001, RC_OK);
    check({14'h0, slot_seen}, 16'h0002);
    rdc(RESP_BASE, 16'h0000);
    rdc(RESP_BASE + 11'h001, 16'h0004);
    load("12345678,9abcdef0");
    run(16'h0C02, 16'h473A, 16'h0001, 16'h0001, RC_OK);
    rdc(RESP_BASE, 16'h9ABC);
    rdc(RESP_BASE + 11'h001, 16'hDEF0);
    load("1234\015\0125678");
    run(16'h0802, 16'h473A, 16'h0000, 16'h0002, RC_IO);
    load("\022\064\126\170");
    wr(RESP_BASE, 16'h5678);
    run(16'h0A03, 16'h473A, 16'h0000, 16'h0001, RC_NOMATCH);
    run(16'h0A03, 16'h473A, 16'h0001, 16'h0001, RC_OK);
    run(16'h0A03, 16'h473A, 16'h0001, 16'h0002, RC_NOMATCH);
    run(16'h0A02, 16'h473A, 16'h0000, 16'h0000, RC_RANGE);
    run(16'h0A02, 16'h473A, 16'h0000, 16'h03E8, RC_RANGE);
    run(16'h0C02, 16'h473A, 16'h0000, 16'h01F4, RC_RANGE);
    run(16'h0A02, 16'h413A, 16'h0000, 16'h0001, RC_NOFILE);
    found = 1'b0;
    run(16'h0A02, 16'h473A, 16'h0000, 16'h0001, RC_NOFILE);
    found = 1'b1;
    run(16'h0202, 16'h473A, 16'h0000, 16'h0001, RC_NOFILE);
    ioerr = 1'b1;
    run(16'h0A02, 16'h473A, 16'h0000, 16'h0001, RC_IO);
    ioerr = 1'b0;
    wr(REG_LEVEL, 16'h0001);
    run(16'h1A03, 16'h473A, 16'h0001, 16'h0001, RC_OK);
    run(16'h0A02, 16'h473A, 16'h0000, 16'h0000, RC_OK);
    run(16'h1B02, 16'h473A, 16'h0000, 16'h0001, RC_OK);
    rdc(RESP_BASE + 11'h001, 16'h0002);
    finish_test();
  end
endmodule
`default_nettype wire

// File: shared/cfr_pkg.sv
// Purpose: shared constants and types for the card file read / compare interpreter
// Assumes: 16-bit register words, word-indexed register addresses
// Notes:   register offsets and status layout are local choices
package cfr_pkg;
  localparam int unsigned ADDR_W     = 11;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned RESP_DEPTH = 1024;
  localparam int unsigned NAME_N     = 7;
  localparam int unsigned FIFO_DEPTH = 8;
  // register map (word index)
  localparam logic [10:0] REG_CTRL   = 11'h000;
  localparam logic [10:0] REG_NAME0  = 11'h001;
  localparam logic [10:0] REG_LEN    = 11'h008;
  localparam logic [10:0] REG_OFFS   = 11'h009;
  localparam logic [10:0] REG_AMT    = 11'h00A;
  localparam logic [10:0] REG_GO     = 11'h00B;
  localparam logic [10:0] REG_STAT   = 11'h00C;
  localparam logic [10:0] REG_LEVEL  = 11'h00D;
  localparam logic [10:0] RESP_BASE  = 11'h400;
  // control, go and status word fields
  localparam int unsigned B_COUNT = 8;
  localparam int unsigned B_BIN   = 9;
  localparam int unsigned B_DBL   = 10;
  localparam int unsigned B_CCE   = 11;
  localparam int unsigned B_LEVEL = 12;
  localparam int unsigned B_GO    = 0;
  localparam int unsigned ST_DONE = 8;
  localparam int unsigned ST_BUSY = 9;
  localparam logic [7:0] PROC_READ = 8'h02;
  localparam logic [7:0] PROC_CMP  = 8'h03;
  // response codes
  localparam logic [7:0] RC_OK      = 8'h00;
  localparam logic [7:0] RC_RANGE   = 8'h01;
  localparam logic [7:0] RC_IO      = 8'h02;
  localparam logic [7:0] RC_NOFILE  = 8'h03;
  localparam logic [7:0] RC_NOMATCH = 8'h04;
  localparam logic [15:0] AMT_MIN      = 16'h0001;
  localparam logic [15:0] AMT_MAX_WORD = 16'h03E7;
  localparam logic [15:0] AMT_MAX_DBL  = 16'h01F3;
  localparam logic [7:0] DRIVE_G = 8'h47;
  localparam logic [7:0] DRIVE_H = 8'h48;
  localparam logic [1:0] SLOT_NONE = 2'h0;
  localparam logic [1:0] SLOT_1    = 2'h1;
  localparam logic [1:0] SLOT_2    = 2'h2;
  localparam logic [7:0] CHR_CR = 8'h0D;
  localparam logic [7:0] CHR_LF = 8'h0A;
  localparam logic [3:0] DIG_WORD = 4'h4;
  localparam logic [3:0] DIG_DBL  = 4'h8;
  // stream word layouts
  localparam int unsigned BYTE_W    = 9;
  localparam int unsigned BYTE_LAST = 8;
  localparam int unsigned ELEM_W    = 35;
  localparam int unsigned E_ERR     = 34;
  localparam int unsigned E_LAST    = 33;
  localparam int unsigned E_EMPTY   = 32;
  typedef enum logic [2:0] {S_IDLE, S_OPEN, S_RUN, S_COPY, S_FIN} cfr_state_t;
endpackage

// File: shared/cfr_strm_if.sv
// Purpose: valid/ready word stream between the interpreter's own modules
// Assumes: word taken on a clock edge with valid and ready both high
// Notes:   framing bits ride inside data
`timescale 1ns/1ps
`default_nettype none
interface cfr_strm_if #(parameter int unsigned W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface
`default_nettype wire
